// *** verilog/timer_pwm_map.svh ***
// Register indices, field positions, reset values and counts of the PWM compare block.
`ifndef TIMER_PWM_MAP_SVH
`define TIMER_PWM_MAP_SVH

// ---------------------------------------------------------------
// Register indices; the byte address is four times the index.
// ---------------------------------------------------------------
`define IDX_PANA   32'h40040061
`define IDX_PDIR   32'h40040321
`define IDX_A0     32'h40042A78
`define IDX_B0     32'h40042A7A
`define IDX_A1     32'h40042A88
`define IDX_B1     32'h40042A8A
`define IDX_C0     32'h40042B58
`define IDX_D0     32'h40042B5A
`define IDX_C1     32'h40042B5C
`define IDX_D1     32'h40042B5E
`define IDX_MODE   32'h40042A70
`define IDX_RUN    32'h40042A71
`define IDX_FUNC   32'h40042A72
`define IDX_CCTL   32'h40042A73
`define IDX_INIT   32'h40042A74
`define IDX_PINLVL 32'h40042A75

// ---------------------------------------------------------------
// Reset values and field positions.
// ---------------------------------------------------------------
`define CMP_RST        16'hFFFF
`define PORT_RST       8'hFF
`define MODE_COMP_BIT  4
`define FUNC_DUAL_BIT  2
`define XSEL_UNDERFLOW 2'h3
`define XSEL_MATCH     2'h2
`define CSEL_SYS       3'h0
`define CSEL_DIV2      3'h1
`define CSEL_DIV4      3'h2
`define CSEL_DIV8      3'h3
`define CSEL_DIV32     3'h4
`define ZERO_REQ_MAX   4'hB
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2

`endif

// *** verilog/timer_pwm_pkg.sv ***
// Types shared by the PWM compare block.
package timer_pwm_pkg;

  // Operating mode of the counter pair.
  typedef enum logic [1:0] {
    MODE_IDLE = 2'b00,
    MODE_COMP = 2'b01,
    MODE_DUAL = 2'b10
  } mode_t;

  // Count direction of the triangle counter.
  typedef enum logic {
    DIR_UP   = 1'b0,
    DIR_DOWN = 1'b1
  } dir_t;

endpackage : timer_pwm_pkg

// *** verilog/cmp_req_gate.sv ***
// Compare request gate that limits requests for a zero compare value.
`timescale 1ns/1ps
`default_nettype none
`include "timer_pwm_map.svh"

module cmp_req_gate (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic start_i,
  input  wire logic match_i,
  input  wire logic zero_i,
  output var  logic req_o
);

  logic [3:0] n_q;    // Requests issued for a zero value since start.
  wire  logic allow;  // Request may pass.

  // A zero value on the fastest clock only fires a fixed burst.
  assign allow = ~zero_i | (n_q != `ZERO_REQ_MAX);

  // ---------------------------------------------------------------
  // Request register and burst counter.
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      n_q   <= 4'h0;
      req_o <= 1'b0;
    end else begin
      req_o <= match_i & allow;
      if (start_i) begin
        n_q <= 4'h0;
      end else if (match_i & zero_i & allow) begin
        n_q <= n_q + 4'h1;
      end
    end
  end

  zero_limit_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (zero_i && match_i && !start_i && n_q == `ZERO_REQ_MAX) |=> !req_o)
    else $error("zero compare request passed after the burst");

endmodule : cmp_req_gate
`default_nettype wire

// *** verilog/timer_pwm_compare_regs.sv ***
// Compare registers, counter and pin control of a two-counter PWM timer.
//
// Overview of operation
// - Complementary running locks period and phase registers.
// - First phase register drives first pin pair.
// - Second phase drives counter one A/C.
// - Third phase drives counter one B/D.
// - Counter zero C pin toggles each half.
// - Counter zero C register idle in complementary.
// - Buffers hold next phase change point.
// - Zero compare on fastest clock: eleven requests.
// - Dual mode: A0 sets the period.
// - Dual mode: A1 sets A active point.
// - Dual mode: B0 sets B return point.
// - Dual mode: B1 sets B active point.
// - Dual mode buffers shadow their partner registers.
// - Compare registers are 16 bits, reset FFFF.
// - Direction zero enables the output buffer unless analog select is one.
// - Analog select one makes the pin analog.
// - Port registers are byte wide, reset FF.
// - Complementary transfer on underflow or period match.
`timescale 1ns/1ps
`default_nettype none
`include "timer_pwm_map.svh"

module timer_pwm_compare_regs
  import timer_pwm_pkg::*;
(
  input  wire logic        SYS_CLK_I,
  input  wire logic        SYS_RST_I,
  input  wire logic [33:0] S_AXI_AWADDR_I,
  input  wire logic        S_AXI_AWVALID_I,
  output var  logic        S_AXI_AWREADY_O,
  input  wire logic [31:0] S_AXI_WDATA_I,
  input  wire logic [3:0]  S_AXI_WSTRB_I,
  input  wire logic        S_AXI_WVALID_I,
  output var  logic        S_AXI_WREADY_O,
  output var  logic [1:0]  S_AXI_BRESP_O,
  output var  logic        S_AXI_BVALID_O,
  input  wire logic        S_AXI_BREADY_I,
  input  wire logic [33:0] S_AXI_ARADDR_I,
  input  wire logic        S_AXI_ARVALID_I,
  output var  logic        S_AXI_ARREADY_O,
  output var  logic [31:0] S_AXI_RDATA_O,
  output var  logic [1:0]  S_AXI_RRESP_O,
  output var  logic        S_AXI_RVALID_O,
  input  wire logic        S_AXI_RREADY_I,
  input  wire logic [7:0]  PORT1_I,
  output var  logic [7:0]  PORT1_O,
  output var  logic [7:0]  PORT1_OE_N_O,
  output var  logic [7:0]  PORT1_ANALOG_O,
  output var  logic [3:0]  CMP_REQ_O
);

  // ---------------------------------------------------------------
  // Address decoder: {hit, index}.
  // ---------------------------------------------------------------
  function automatic logic [4:0] dec(input logic [33:0] a);
    logic [4:0] r;
    r = 5'h00;
    unique case (a[33:2])
      `IDX_A0:     r = 5'h10;
      `IDX_B0:     r = 5'h11;
      `IDX_C0:     r = 5'h12;
      `IDX_D0:     r = 5'h13;
      `IDX_A1:     r = 5'h14;
      `IDX_B1:     r = 5'h15;
      `IDX_C1:     r = 5'h16;
      `IDX_D1:     r = 5'h17;
      `IDX_PANA:   r = 5'h18;
      `IDX_PDIR:   r = 5'h19;
      `IDX_MODE:   r = 5'h1A;
      `IDX_RUN:    r = 5'h1B;
      `IDX_FUNC:   r = 5'h1C;
      `IDX_CCTL:   r = 5'h1D;
      `IDX_INIT:   r = 5'h1E;
      `IDX_PINLVL: r = 5'h1F;
      default:     r = 5'h00;
    endcase
    dec = (a[1:0] == 2'h0) ? r : 5'h00;
  endfunction : dec

  // Byte-lane merge of a 16-bit register.
  function automatic logic [15:0] mrg(input logic [15:0] o, input logic [31:0] d,
                                      input logic [3:0] s);
    mrg = {s[1] ? d[15:8] : o[15:8], s[0] ? d[7:0] : o[7:0]};
  endfunction : mrg

  // ---------------------------------------------------------------
  // State.
  // ---------------------------------------------------------------
  logic [33:0] awaddr_q;     // Captured write address.
  logic [31:0] wdata_q;      // Captured write data.
  logic [3:0]  wstrb_q;      // Captured write strobes.
  logic [15:0] cmp_q [8];    // A0 B0 C0 D0 A1 B1 C1 D1.
  logic [7:0]  pana_q;       // port1_analog_select.
  logic [7:0]  pdir_q;       // port1_direction.
  logic [4:0]  mode_q;       // timer_mode_control: comp enable, buffer selects.
  logic [1:0]  run_q;        // timer_run_control: run bits one and zero.
  logic [2:0]  func_q;       // timer_function_control: dual bit, transfer select.
  logic [2:0]  csel_q;       // counter_control: count clock select.
  logic [15:0] init_q;       // Initial count of counter zero.
  logic [7:0]  pin_lvl_q;    // Sampled digital pin levels.
  logic [15:0] cnt_q;        // Counter value.
  dir_t        dir_q;        // Count direction.
  logic [4:0]  pre_q;        // Prescaler.
  logic        tog_q;        // Half-period toggle.
  logic        run_d1_q;     // Run state one cycle ago.
  logic        rd8_q;        // Last read hit a port register.

  // ---------------------------------------------------------------
  // Decode and control wires.
  // ---------------------------------------------------------------
  wire logic [4:0] wdec   = dec(awaddr_q);
  wire logic [4:0] rdec   = dec(S_AXI_ARADDR_I);
  wire logic       do_wr  = ~S_AXI_AWREADY_O & ~S_AXI_WREADY_O & ~S_AXI_BVALID_O;
  wire logic       wr_hit = do_wr & wdec[4];
  wire logic [3:0] widx   = wdec[3:0];
  wire logic       rd_go  = S_AXI_ARVALID_I & S_AXI_ARREADY_O;
  wire mode_t      mode   = func_q[`FUNC_DUAL_BIT] ? MODE_DUAL :
                            mode_q[`MODE_COMP_BIT] ? MODE_COMP : MODE_IDLE;
  wire logic [3:0] bsel   = mode_q[3:0]; // Buffer selects C0 D0 C1 D1.
  wire logic [1:0] xsel   = func_q[1:0]; // complementary_transfer_sel.
  wire logic       locked = (mode == MODE_COMP) & run_q[0] & run_q[1];
  wire logic       run    = run_q[0] & (mode != MODE_IDLE) &
                            ((mode == MODE_DUAL) | run_q[1]);
  wire logic       start  = run & ~run_d1_q;

  // The prescaler runs freely, so the first tick after a start may come early.
  wire logic tick = run & (((csel_q == `CSEL_SYS))              |
                           ((csel_q == `CSEL_DIV2)  & pre_q[0])   |
                           ((csel_q == `CSEL_DIV4)  & &pre_q[1:0]) |
                           ((csel_q == `CSEL_DIV8)  & &pre_q[2:0]) |
                           ((csel_q == `CSEL_DIV32) & &pre_q));

  wire logic comp = (mode == MODE_COMP);
  wire logic dual = (mode == MODE_DUAL);
  // Period match and underflow of the triangle count.
  wire logic top  = tick & comp & (dir_q == DIR_UP) & (cnt_q == cmp_q[0]);
  wire logic bot  = tick & comp & (dir_q == DIR_DOWN) & (cnt_q == init_q);
  wire logic wrap = tick & dual & (cnt_q >= cmp_q[0]);
  wire logic cx   = ((xsel == `XSEL_UNDERFLOW) & bot) |
                    ((xsel == `XSEL_MATCH) & top);
  wire logic ev   = cx | wrap;

  // Buffer transfers into A0, B0, A1, B1; C0 never moves in complementary mode.
  wire logic [7:0] xfr = {2'b00, ev & bsel[3], ev & bsel[2],
                          2'b00, ev & bsel[1], wrap & bsel[0]};

  // Phase comparisons.
  wire logic ph0    = cnt_q > cmp_q[1];
  wire logic ph1    = cnt_q > cmp_q[4];
  wire logic ph2    = cnt_q > cmp_q[5];
  wire logic a1_hit = cnt_q >= cmp_q[4];
  wire logic d_a    = a1_hit;
  wire logic d_b    = (cnt_q >= cmp_q[5]) & (cnt_q < cmp_q[1]);
  wire logic c0_nx  = tog_q ^ (top | bot);

  wire logic [7:0] pin_d = comp ? {~ph2, ~ph1, ph2, ph1, ~ph0, c0_nx, ph0, 1'b0} :
                           dual ? {6'h00, d_b, d_a} : 8'h00;

  // ---------------------------------------------------------------
  // Write channel: address and data taken in either order.
  // ---------------------------------------------------------------
  always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      S_AXI_AWREADY_O <= 1'b1;
      S_AXI_WREADY_O  <= 1'b1;
      S_AXI_BVALID_O  <= 1'b0;
      S_AXI_BRESP_O   <= `RESP_OKAY;
      awaddr_q        <= 34'h0;
      wdata_q         <= 32'h0;
      wstrb_q         <= 4'h0;
    end else begin
      if (S_AXI_AWVALID_I & S_AXI_AWREADY_O) begin
        awaddr_q        <= S_AXI_AWADDR_I;
        S_AXI_AWREADY_O <= 1'b0;
      end
      if (S_AXI_WVALID_I & S_AXI_WREADY_O) begin
        wdata_q        <= S_AXI_WDATA_I;
        wstrb_q        <= S_AXI_WSTRB_I;
        S_AXI_WREADY_O <= 1'b0;
      end
      if (do_wr) begin
        // A refused write still answers OKAY; only an unmapped or unaligned one errs.
        S_AXI_BVALID_O <= 1'b1;
        S_AXI_BRESP_O  <= wdec[4] ? `RESP_OKAY : `RESP_SLVERR;
      end else if (S_AXI_BVALID_O & S_AXI_BREADY_I) begin
        S_AXI_BVALID_O  <= 1'b0;
        S_AXI_AWREADY_O <= 1'b1;
        S_AXI_WREADY_O  <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Compare registers: bus write first, else buffer transfer.
  // ---------------------------------------------------------------
  for (genvar k = 0; k < 8; k++) begin : g_cmp
    // A and B registers are refused while both counters run in complementary mode.
    wire logic we = wr_hit & (widx == 4'(k)) & ~(locked & ~k[1]);
    always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
        cmp_q[k] <= `CMP_RST;
      end else if (we) begin
        cmp_q[k] <= mrg(cmp_q[k], wdata_q, wstrb_q);
      end else if (xfr[k]) begin
        cmp_q[k] <= cmp_q[k ^ 2];
      end
    end
  end

  // ---------------------------------------------------------------
  // Control and port registers; byte-wide ones take lane zero only.
  // ---------------------------------------------------------------
  wire logic bw = wr_hit & wstrb_q[0];

  always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      pana_q <= `PORT_RST;
      pdir_q <= `PORT_RST;
      mode_q <= 5'h00;
      run_q  <= 2'h0;
      func_q <= 3'h0;
      csel_q <= `CSEL_SYS;
      init_q <= 16'h0000;
    end else begin
      if (bw & (widx == 4'h8)) pana_q <= wdata_q[7:0];
      if (bw & (widx == 4'h9)) pdir_q <= wdata_q[7:0];
      if (bw & (widx == 4'hA)) mode_q <= wdata_q[4:0];
      if (bw & (widx == 4'hB)) run_q  <= wdata_q[1:0];
      if (bw & (widx == 4'hC)) func_q <= wdata_q[2:0];
      if (bw & (widx == 4'hD)) csel_q <= wdata_q[2:0];
      if (wr_hit & (widx == 4'hE)) init_q <= mrg(init_q, wdata_q, wstrb_q);
    end
  end

  // ---------------------------------------------------------------
  // Counter, prescaler and half-period toggle.
  // ---------------------------------------------------------------
  always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      cnt_q    <= 16'h0000;
      dir_q    <= DIR_UP;
      pre_q    <= 5'h00;
      tog_q    <= 1'b0;
      run_d1_q <= 1'b0;
    end else begin
      pre_q    <= pre_q + 5'h01;
      run_d1_q <= run;
      tog_q    <= c0_nx;
      if (start) begin
        cnt_q <= comp ? init_q : 16'h0000;
        dir_q <= DIR_UP;
      end else if (top) begin
        cnt_q <= cnt_q - 16'h0001;
        dir_q <= DIR_DOWN;
      end else if (bot) begin
        cnt_q <= cnt_q + 16'h0001;
        dir_q <= DIR_UP;
      end else if (tick) begin
        // Dual mode restarts from zero after the period value.
        cnt_q <= wrap ? 16'h0000 :
                 (comp & (dir_q == DIR_DOWN)) ? cnt_q - 16'h0001 : cnt_q + 16'h0001;
      end
    end
  end

  // ---------------------------------------------------------------
  // Pins: timer levels, buffer enables and analog selects.
  // ---------------------------------------------------------------
  always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      PORT1_O        <= 8'h00;
      PORT1_OE_N_O   <= 8'hFF;
      PORT1_ANALOG_O <= `PORT_RST;
      pin_lvl_q      <= 8'h00;
    end else begin
      PORT1_O        <= pin_d;
      PORT1_OE_N_O   <= pdir_q | pana_q;
      PORT1_ANALOG_O <= pana_q;
      pin_lvl_q      <= PORT1_I & ~pana_q;
    end
  end

  // ---------------------------------------------------------------
  // Read channel: one cycle from address to data.
  // ---------------------------------------------------------------
  logic [31:0] rd_word; // Word selected by the read index.

  always_comb begin
    rd_word = 32'h0000_0000;
    if (!rdec[3]) begin
      rd_word = {16'h0000, cmp_q[rdec[2:0]]};
    end else begin
      unique case (rdec[2:0])
        3'h0: rd_word = {24'h0, pana_q};
        3'h1: rd_word = {24'h0, pdir_q};
        3'h2: rd_word = {27'h0, mode_q};
        3'h3: rd_word = {30'h0, run_q};
        3'h4: rd_word = {29'h0, func_q};
        3'h5: rd_word = {29'h0, csel_q};
        3'h6: rd_word = {16'h0, init_q};
        3'h7: rd_word = {24'h0, pin_lvl_q};
      endcase
    end
  end

  always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      S_AXI_ARREADY_O <= 1'b1;
      S_AXI_RVALID_O  <= 1'b0;
      S_AXI_RDATA_O   <= 32'h0;
      S_AXI_RRESP_O   <= `RESP_OKAY;
      rd8_q           <= 1'b0;
    end else if (rd_go) begin
      S_AXI_ARREADY_O <= 1'b0;
      S_AXI_RVALID_O  <= 1'b1;
      S_AXI_RDATA_O   <= rdec[4] ? rd_word : 32'h0;
      S_AXI_RRESP_O   <= rdec[4] ? `RESP_OKAY : `RESP_SLVERR;
      rd8_q           <= rdec[4] & (rdec[3:1] == 3'h4);
    end else if (S_AXI_RVALID_O & S_AXI_RREADY_I) begin
      S_AXI_RVALID_O  <= 1'b0;
      S_AXI_ARREADY_O <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Compare requests to the event link, one gate per channel.
  // ---------------------------------------------------------------
  wire logic [15:0] rv [4];
  assign rv[0] = cmp_q[0];
  assign rv[1] = cmp_q[1];
  assign rv[2] = cmp_q[4];
  assign rv[3] = cmp_q[5];

  for (genvar j = 0; j < 4; j++) begin : g_req
    cmp_req_gate u_gate (
      .clk_i   (SYS_CLK_I),
      .rst_i   (SYS_RST_I),
      .start_i (start),
      // The start cycle still holds the stale count, so it never matches.
      .match_i (tick & ~start & (cnt_q == rv[j])),
      .zero_i  ((csel_q == `CSEL_SYS) & (rv[j] == 16'h0000)),
      .req_o   (CMP_REQ_O[j])
    );
  end

  // ---------------------------------------------------------------
  // Assertions.
  // ---------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (SYS_RST_I);

  sequence s_half;
    comp && (top || bot);
  endsequence

  sequence s_under_xfer;
    comp && xsel == `XSEL_UNDERFLOW && bot && bsel[1] && !(wr_hit && widx == 4'h1);
  endsequence

  lock_write_a: assert property (wr_hit && widx == 4'h0 && locked
    |=> cmp_q[0] == $past(cmp_q[0])) else $error("locked period register was written");

  half_toggle_a: assert property (s_half |=> PORT1_O[2] != $past(PORT1_O[2]))
    else $error("half-period pin did not toggle");

  c0_idle_a: assert property (comp && wr_hit && widx == 4'h2 && !top && !bot
    |=> $stable(PORT1_O[2])) else $error("idle register moved an output");

  under_xfer_a: assert property (s_under_xfer |=> cmp_q[1] == $past(cmp_q[3]))
    else $error("buffer not transferred on underflow");

  dual_xfer_a: assert property (dual && wrap && bsel[0]
    && !(wr_hit && widx == 4'h0) |=> cmp_q[0] == $past(cmp_q[2]))
    else $error("period buffer not transferred");

  dual_active_a: assert property (dual && $past(dual) && $rose(PORT1_O[0])
    |-> $past(a1_hit)) else $error("channel A went active early");

  out_buf_a: assert property (!pdir_q[0] && !pana_q[0] ##1 !pdir_q[0] && !pana_q[0]
    |-> !PORT1_OE_N_O[0]) else $error("output buffer off in output mode");

  analog_in_a: assert property (pana_q[1] ##1 pana_q[1] |-> !pin_lvl_q[1])
    else $error("analog pin read as digital");

  narrow_rd_a: assert property (S_AXI_RVALID_O && rd8_q
    |-> S_AXI_RDATA_O[31:8] == 24'h0) else $error("byte register read with upper bits set");

endmodule : timer_pwm_compare_regs
`default_nettype wire

// *** testbench/pwm_load_model.sv ***
// Load model that stands on the timer pins and drives their levels back.
`timescale 1ns/1ps
`default_nettype none
module pwm_load_model (
  input  wire logic       clk_i,
  input  wire logic [7:0] pin_i,
  input  wire logic [7:0] oe_n_i,
  output var  logic [7:0] level_o
);
  // -------------------------------------------------------------
  // Released pins float with no pull.
  // -------------------------------------------------------------
  logic [7:0] float_q = 8'h00; // Flips bits 0, 2, 5 and 7 each cycle; bits 1, 3, 4 and 6 stay 0.
  // Pattern for undriven pins.
  always_ff @(posedge clk_i) begin
    float_q <= ~float_q ^ 8'h5A;
  end
  // A pin whose output buffer is on shows the timer level, any other floats.
  assign level_o = (pin_i & ~oe_n_i) | (float_q & oe_n_i);
endmodule : pwm_load_model
`default_nettype wire

// *** testbench/timer_pwm_compare_regs_tb.sv ***
// Self-checking testbench of the PWM compare register block.
`timescale 1ns/1ps
`default_nettype none
`include "timer_pwm_map.svh"
module timer_pwm_compare_regs_tb;
  logic        clk, rst, aw_v, w_v, b_r, ar_v, r_r; // Clock, reset and handshakes.
  logic [33:0] aw_a, ar_a;                          // Byte addresses.
  logic [31:0] w_d;                                 // Write data.
  logic [3:0]  w_s;                                 // Byte lanes.
  logic [7:0]  pin_o, oe_n, ana, lvl;               // Pin side.
  logic [3:0]  req;                                 // Compare requests.
  logic        aw_rdy, w_rdy, b_vld, ar_rdy, r_vld; // Slave handshakes.
  logic [1:0]  b_rsp, r_rsp;                        // Response codes.
  logic [31:0] r_dat;                               // Read data.
  int          fails, tests_run;                    // Tallies.
  typedef struct { logic [31:0] idx; logic [31:0] mask; } row_t;
  // Reset value equals the width mask: every listed register resets to all ones.
  row_t rows [10] = '{'{`IDX_PANA, 32'hFF}, '{`IDX_PDIR, 32'hFF}, '{`IDX_A0, 32'hFFFF},
    '{`IDX_B0, 32'hFFFF}, '{`IDX_A1, 32'hFFFF}, '{`IDX_B1, 32'hFFFF}, '{`IDX_C0, 32'hFFFF},
    '{`IDX_D0, 32'hFFFF}, '{`IDX_C1, 32'hFFFF}, '{`IDX_D1, 32'hFFFF}};
  timer_pwm_compare_regs uut (.SYS_CLK_I(clk), .SYS_RST_I(rst), .S_AXI_AWADDR_I(aw_a),
    .S_AXI_AWVALID_I(aw_v), .S_AXI_AWREADY_O(aw_rdy), .S_AXI_WDATA_I(w_d),
    .S_AXI_WSTRB_I(w_s), .S_AXI_WVALID_I(w_v), .S_AXI_WREADY_O(w_rdy),
    .S_AXI_BRESP_O(b_rsp), .S_AXI_BVALID_O(b_vld), .S_AXI_BREADY_I(b_r),
    .S_AXI_ARADDR_I(ar_a), .S_AXI_ARVALID_I(ar_v), .S_AXI_ARREADY_O(ar_rdy),
    .S_AXI_RDATA_O(r_dat), .S_AXI_RRESP_O(r_rsp), .S_AXI_RVALID_O(r_vld),
    .S_AXI_RREADY_I(r_r), .PORT1_I(lvl), .PORT1_O(pin_o), .PORT1_OE_N_O(oe_n),
    .PORT1_ANALOG_O(ana), .CMP_REQ_O(req));
  pwm_load_model load (.clk_i(clk), .pin_i(pin_o), .oe_n_i(oe_n), .level_o(lvl));
  // -------------------------------------------------------------
  // Shared tasks.
  // -------------------------------------------------------------
  function automatic logic [33:0] adr(input logic [31:0] idx);
    return {idx, 2'b00};
  endfunction : adr
  // Compares a seen value against the expected one.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Write: both channels offered together, each dropped when taken.
  task automatic wr(input logic [33:0] a, input logic [31:0] d, output logic [1:0] r);
    aw_a <= a; w_d <= d; w_s <= 4'hF; aw_v <= 1'b1; w_v <= 1'b1; b_r <= 1'b1;
    do begin
      @(posedge clk);
      if (aw_v && aw_rdy) aw_v <= 1'b0;
      if (w_v && w_rdy) w_v <= 1'b0;
    end while (b_vld !== 1'b1);
    r = b_rsp;
  endtask : wr
  // Read: address held until taken, ready held until data seen.
  task automatic rd(input logic [33:0] a, output logic [31:0] d, output logic [1:0] r);
    ar_a <= a; ar_v <= 1'b1; r_r <= 1'b1;
    do begin
      @(posedge clk);
      if (ar_v && ar_rdy) ar_v <= 1'b0;
    end while (r_vld !== 1'b1);
    d = r_dat;
    r = r_rsp;
  endtask : rd
  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : report_and_stop
  // Clock of 8 ns.
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Watchdog well beyond the expected run of under two thousand cycles.
  initial begin
    repeat (30000) @(posedge clk);
    fails++;
    report_and_stop();
  end
  // -------------------------------------------------------------
  // Main sequence.
  // -------------------------------------------------------------
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    int          n, tog, bad;
    logic        prev;
    rst = 1'b1; aw_v = 1'b0; w_v = 1'b0; b_r = 1'b0; ar_v = 1'b0; r_r = 1'b0;
    aw_a = '0; ar_a = '0; w_d = '0; w_s = '0; fails = 0; tests_run = 0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    // Reset values, then write and read back with upper lanes ignored.
    foreach (rows[i]) begin
      rd(adr(rows[i].idx), d, r);
      check(d, rows[i].mask);
      wr(adr(rows[i].idx), 32'h12345AA5, r);
      rd(adr(rows[i].idx), d, r);
      check(d, 32'h12345AA5 & rows[i].mask);
    end
    $display("register rows done");
    // Port control: enable is low only where direction and analog are both 0.
    check(32'(oe_n), 32'hA5);
    check(32'(ana), 32'hA5);
    wr(adr(`IDX_PANA), 32'h01, r); // Pin 0 set analog.
    wr(adr(`IDX_PDIR), 32'h0E, r); // Pins 1 to 3 in, 4 to 7 out
    repeat (2) @(posedge clk);
    check(32'(oe_n), 32'h0F);
    check(32'(ana), 32'h01);
    // The analog pin reads low; idle timer outputs loop back low.
    rd(adr(`IDX_PINLVL), d, r);
    check(d & 32'hF1, 32'h0);
    wr(adr(`IDX_PANA), 32'h00, r);
    wr(adr(`IDX_PDIR), 32'h00, r);
    $display("port test done");
    // Complementary run with a locked write, then D0 moved into B0 on underflow.
    wr(adr(`IDX_INIT), 32'h0, r);
    check(32'(oe_n), 32'h0);
    wr(adr(`IDX_A0), 32'h10, r);
    wr(adr(`IDX_B0), 32'h08, r);
    wr(adr(`IDX_D0), 32'h08, r);
    wr(adr(`IDX_A1), 32'h06, r);
    wr(adr(`IDX_B1), 32'h0A, r);
    wr(adr(`IDX_CCTL), 32'h3, r);
    wr(adr(`IDX_FUNC), 32'h3, r); // Transfer on underflow.
    wr(adr(`IDX_MODE), 32'h12, r);
    wr(adr(`IDX_RUN), 32'h3, r);
    wr(adr(`IDX_A0), 32'h20, r);
    check(32'(r), 32'(`RESP_OKAY));
    rd(adr(`IDX_A0), d, r);
    check(d, 32'h10);
    wr(adr(`IDX_C0), 32'h0, r); // Idle register written mid-run.
    wr(adr(`IDX_D0), 32'h05, r); // Next change point
    tog = 0; bad = 0; prev = pin_o[2];
    repeat (1024) begin
      @(posedge clk);
      if (pin_o[2] !== prev) tog++;
      prev = pin_o[2];
      if (pin_o[1] === pin_o[3] || pin_o[4] === pin_o[6] || pin_o[5] === pin_o[7]) bad++;
    end
    check(32'(bad), 32'h0);
    check({31'h0, tog >= 7 && tog <= 9}, 32'h1);
    rd(adr(`IDX_B0), d, r);
    check(d, 32'h05);
    // One run bit alone does not lock.
    wr(adr(`IDX_RUN), 32'h1, r);
    wr(adr(`IDX_A0), 32'h30, r);
    rd(adr(`IDX_A0), d, r);
    check(d, 32'h30);
    $display("complementary test done");
    // Zero compare on the fastest clock: request count limited.
    wr(adr(`IDX_RUN), 32'h0, r);
    wr(adr(`IDX_MODE), 32'h0, r);
    wr(adr(`IDX_FUNC), 32'h4, r);
    wr(adr(`IDX_CCTL), 32'h0, r); // Internal clock only
    wr(adr(`IDX_A0), 32'h0, r);
    wr(adr(`IDX_RUN), 32'h1, r);
    n = 0;
    bad = 0;
    repeat (200) begin
      @(posedge clk);
      if (req[0] === 1'b1) n++;
      if (req[3:1] !== 3'h0) bad++;
    end
    check(32'(n), 32'd11);
    check(32'(bad), 32'h0);
    $display("zero compare test done");
    // Dual outputs on every clock; C0 buffers the next period of 32 counts.
    wr(adr(`IDX_RUN), 32'h0, r);
    wr(adr(`IDX_A0), 32'h0F, r);
    wr(adr(`IDX_A1), 32'h04, r);
    wr(adr(`IDX_B0), 32'h0C, r);
    wr(adr(`IDX_B1), 32'h08, r);
    wr(adr(`IDX_C0), 32'h1F, r);
    wr(adr(`IDX_MODE), 32'h01, r);
    wr(adr(`IDX_RUN), 32'h1, r);
    repeat (40) @(posedge clk);
    rd(adr(`IDX_A0), d, r);
    check(d, 32'h1F);
    n = 0;
    tog = 0;
    bad = 0;
    // Ten whole periods: A high from count 4 on, B high for counts 8 to 11.
    repeat (320) begin
      @(posedge clk);
      n += $countones(req);
      tog += int'(pin_o[0]);
      bad += int'(pin_o[1]);
    end
    check(32'(tog), 32'd280);
    check(32'(bad), 32'd40);
    check(32'(n), 32'd40);
    $display("dual output test done");
    // Unmapped and unaligned accesses.
    wr(34'h0, 32'h1, r);
    check(32'(r), 32'(`RESP_SLVERR));
    wr(adr(`IDX_A0) | 34'h1, 32'h1, r);
    check(32'(r), 32'(`RESP_SLVERR));
    rd(34'h0, d, r);
    check(d, 32'h0);
    check(32'(r), 32'(`RESP_SLVERR));
    $display("unmapped test done");
    // A reset in mid-run brings every register back.
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check(32'(oe_n), 32'hFF);
    rd(adr(`IDX_A0), d, r);
    check(d, 32'hFFFF);
    rd(adr(`IDX_PDIR), d, r);
    check(d, 32'hFF);
    $display("reset test done");
    report_and_stop();
  end
endmodule : timer_pwm_compare_regs_tb
`default_nettype wire
